/* bench/bce_branch_condition_evaluator_properties.sv */
// Concurrent checks on the evaluator ports
`timescale 1ns/1ps
`default_nettype none
module bce_branch_condition_evaluator_properties (input wire logic clock, resetn, is_conditional_jump,
    flag_carry, flag_zero, flag_sign, flag_overflow, take_jump, input wire logic [7:0] opcode,
    input wire logic [3:0] branch_condition_field);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    wire j = is_conditional_jump, n = opcode[7], t = take_jump, x = flag_sign ^ flag_overflow;
    wire [2:0] k = opcode[6:4];
    wire [3:0] p = {flag_carry, flag_zero, flag_sign, flag_overflow};
    a_field_bits: assert property (branch_condition_field == opcode[7:4]) else $error("field");
    a_gate_low: assert property (!j |-> !t) else $error("gate");
    a_fixed_test: assert property (j && k == 0 |-> t == n) else $error("fixed");
    a_signed_below: assert property (j && k == 1 |-> t == (x ^ n)) else $error("signed below");
    a_signed_most: assert property (j && k == 2 |-> t == ((flag_zero | x) ^ n)) else $error("signed most");
    a_unsigned_most: assert property (j && k == 3 |-> t == ((p[3] | p[2]) ^ n)) else $error("unsigned");
    a_wrap_sign: assert property (j && k[2:1] == 2 |-> t == (p[k[1:0]] ^ n)) else $error("vs");
    a_zero_carry: assert property (j && k[2:1] == 3 |-> t == (p[k[1:0]] ^ n)) else $error("zc");
endmodule
bind bce_branch_condition_evaluator bce_branch_condition_evaluator_properties i_bce_branch_condition_evaluator_properties (.*);
`default_nettype wire

/* bench/bce_branch_condition_evaluator_tb.sv */
// Exhaustive bench for the branch condition evaluator
`timescale 1ns/1ps
`default_nettype none
module bce_branch_condition_evaluator_tb;
    logic clock = 0, resetn = 0, q = 0, tj;
    logic [7:0] k = 0, opc;
    logic [3:0] f, fld;
    int n_mismatch = 0, checked = 0;
    initial forever #5 clock = ~clock;
    bce_decoder_model i_bce_decoder_model (.k(k), .opcode(opc), .f(f));
    bce_branch_condition_evaluator i_bce_branch_condition_evaluator (.clock(clock), .resetn(resetn),
        .opcode(opc), .is_conditional_jump(q), .flag_carry(f[3]), .flag_zero(f[2]), .flag_sign(f[1]),
        .flag_overflow(f[0]), .take_jump(tj), .branch_condition_field(fld));
    task cmp_field(input logic [3:0] a, b);
        checked++;
        if (a !== b) n_mismatch++;
        if (a !== b) $display("BAD %0t %h %h", $time, a, b);
    endtask
    task cmp_jump(input logic a, b);
        checked++;
        if (a !== b) n_mismatch++;
        if (a !== b) $display("BAD %0t %h %h", $time, a, b);
    endtask
    // Every selector against every flag mix, qualified or not
    task sweep(input logic g);
        logic [7:0] t;
        for (int i = 0; i < 256; i++)
        begin
            @(posedge clock) #1 {k, q} = {i[7:0], g};
            t = {k[3], k[2], k[1], k[0], k[3] | k[2], k[2] | (k[1] ^ k[0]), k[1] ^ k[0], 1'b0};
            #4 cmp_field(fld, k[7:4]);
            cmp_jump(tj, g & (t[k[6:4]] ^ k[7]));
        end
    endtask
    // Stateless block: reset must not change any decision
    task sweep_in_reset;
        @(posedge clock) #1 resetn = 0;
        sweep(1'b1);
        @(posedge clock) #1 resetn = 1;
    endtask
    task complete_run;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clock);
        #1 resetn = 1;
        sweep(1'b1);
        sweep(1'b0);
        sweep_in_reset;
        sweep(1'b1);
        complete_run;
    end
endmodule
`default_nettype wire

/* bench/bce_decoder_model.sv */
// Decoder side: forms opcode byte and flags
`timescale 1ns/1ps
`default_nettype none
module bce_decoder_model (input wire logic [7:0] k, output logic [7:0] opcode, output logic [3:0] f);
    // Low nibble differs from the selector so a wrong slice shows
    assign opcode = {k[7:4], ~k[7:4]};
    assign f = k[3:0];
endmodule
`default_nettype wire

/* common/bce_pkg.sv */
// Constants and types for the branch condition evaluator
package bce_pkg;
    localparam int BCE_OPC_W = 8;
    localparam int BCE_SEL_HI = 7;
    localparam int BCE_SEL_LO = 4;
    localparam int BCE_SEL_W = 4;

    typedef logic [BCE_SEL_W-1:0] bce_sel_t;

    localparam bce_sel_t BCE_NEVER = 4'h0;
    localparam bce_sel_t BCE_SIGNED_BELOW = 4'h1;
    localparam bce_sel_t BCE_SIGNED_AT_MOST = 4'h2;
    localparam bce_sel_t BCE_UNSIGNED_AT_MOST = 4'h3;
    localparam bce_sel_t BCE_ARITH_WRAP_SET = 4'h4;
    localparam bce_sel_t BCE_NEGATIVE_RESULT = 4'h5;
    localparam bce_sel_t BCE_OPERANDS_MATCH = 4'h6;
    localparam bce_sel_t BCE_UNSIGNED_BELOW = 4'h7;
    localparam bce_sel_t BCE_ALWAYS = 4'h8;
    localparam bce_sel_t BCE_SIGNED_AT_LEAST = 4'h9;
    localparam bce_sel_t BCE_SIGNED_ABOVE = 4'ha;
    localparam bce_sel_t BCE_UNSIGNED_ABOVE = 4'hb;
    localparam bce_sel_t BCE_ARITH_WRAP_CLEAR = 4'hc;
    localparam bce_sel_t BCE_NONNEGATIVE_RESULT = 4'hd;
    localparam bce_sel_t BCE_OPERANDS_DIFFER = 4'he;
    localparam bce_sel_t BCE_UNSIGNED_AT_LEAST = 4'hf;
endpackage

/* verilog/bce_branch_condition_evaluator.sv */
// Combinational take-jump decision for conditional jumps
`timescale 1ns/1ps
`default_nettype none
module bce_branch_condition_evaluator
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [bce_pkg::BCE_OPC_W-1:0] opcode,
    input wire logic is_conditional_jump,
    input wire logic flag_carry,
    input wire logic flag_zero,
    input wire logic flag_sign,
    input wire logic flag_overflow,
    output logic take_jump,
    output logic [bce_pkg::BCE_SEL_W-1:0] branch_condition_field
);
    import bce_pkg::*;

    // Pure logic; clock and reset kept only for a uniform core port list
    logic unused_ok;
    assign unused_ok = clock ^ resetn;

    // One test per selector code
    localparam int BCE_N_TESTS = 2 ** BCE_SEL_W;

    typedef logic [BCE_N_TESTS-1:0] bce_vec_t;

    // Flags travel as one bundle so no other input can reach the tests
    typedef struct packed
    {
        logic carry;
        logic zero;
        logic sign;
        logic overflow;
    } bce_flags_s;

    // Every intermediate of one evaluation, visible in one place
    typedef struct packed
    {
        bce_flags_s flags;
        bce_sel_t sel;
        bce_vec_t hot;
        bce_vec_t tests;
        logic hit;
    } bce_eval_s;

    bce_eval_s eval_now;

    // Low nibble belongs to the addressing form and is ignored here
    function automatic bce_sel_t bce_select(input logic [BCE_OPC_W-1:0] opc);
        bce_select = opc[BCE_SEL_HI:BCE_SEL_LO];
    endfunction

    // Only these four flags enter the tests
    function automatic bce_flags_s bce_bundle(input logic c, input logic z, input logic s, input logic v);
        bce_flags_s f;
        f.carry = c;
        f.zero = z;
        f.sign = s;
        f.overflow = v;
        bce_bundle = f;
    endfunction

    // Written out as a table so each selector code is visible
    function automatic bce_vec_t bce_onehot(input bce_sel_t sel);
        bce_vec_t hot;
        hot = '0;
        hot[BCE_NEVER] = (sel == BCE_NEVER);
        hot[BCE_SIGNED_BELOW] = (sel == BCE_SIGNED_BELOW);
        hot[BCE_SIGNED_AT_MOST] = (sel == BCE_SIGNED_AT_MOST);
        hot[BCE_UNSIGNED_AT_MOST] = (sel == BCE_UNSIGNED_AT_MOST);
        hot[BCE_ARITH_WRAP_SET] = (sel == BCE_ARITH_WRAP_SET);
        hot[BCE_NEGATIVE_RESULT] = (sel == BCE_NEGATIVE_RESULT);
        hot[BCE_OPERANDS_MATCH] = (sel == BCE_OPERANDS_MATCH);
        hot[BCE_UNSIGNED_BELOW] = (sel == BCE_UNSIGNED_BELOW);
        hot[BCE_ALWAYS] = (sel == BCE_ALWAYS);
        hot[BCE_SIGNED_AT_LEAST] = (sel == BCE_SIGNED_AT_LEAST);
        hot[BCE_SIGNED_ABOVE] = (sel == BCE_SIGNED_ABOVE);
        hot[BCE_UNSIGNED_ABOVE] = (sel == BCE_UNSIGNED_ABOVE);
        hot[BCE_ARITH_WRAP_CLEAR] = (sel == BCE_ARITH_WRAP_CLEAR);
        hot[BCE_NONNEGATIVE_RESULT] = (sel == BCE_NONNEGATIVE_RESULT);
        hot[BCE_OPERANDS_DIFFER] = (sel == BCE_OPERANDS_DIFFER);
        hot[BCE_UNSIGNED_AT_LEAST] = (sel == BCE_UNSIGNED_AT_LEAST);
        bce_onehot = hot;
    endfunction

    // Fixed outcomes, kept as functions so the table reads uniformly
    function automatic logic bce_never();
        bce_never = 1'b0;
    endfunction

    function automatic logic bce_always();
        bce_always = 1'b1;
    endfunction

    // True-sense tests; each also feeds its inverted selector
    function automatic logic bce_signed_below(input bce_flags_s f);
        bce_signed_below = f.sign ^ f.overflow;
    endfunction

    function automatic logic bce_signed_at_most(input bce_flags_s f);
        bce_signed_at_most = f.zero | bce_signed_below(f);
    endfunction

    function automatic logic bce_unsigned_at_most(input bce_flags_s f);
        bce_unsigned_at_most = f.carry | f.zero;
    endfunction

    function automatic logic bce_arith_wrap_set(input bce_flags_s f);
        bce_arith_wrap_set = f.overflow;
    endfunction

    function automatic logic bce_negative_result(input bce_flags_s f);
        bce_negative_result = f.sign;
    endfunction

    function automatic logic bce_operands_match(input bce_flags_s f);
        bce_operands_match = f.zero;
    endfunction

    function automatic logic bce_unsigned_below(input bce_flags_s f);
        bce_unsigned_below = f.carry;
    endfunction

    // Inverted-sense tests, selector bit 3 set
    function automatic logic bce_signed_at_least(input bce_flags_s f);
        bce_signed_at_least = ~bce_signed_below(f);
    endfunction

    function automatic logic bce_signed_above(input bce_flags_s f);
        bce_signed_above = ~bce_signed_at_most(f);
    endfunction

    function automatic logic bce_unsigned_above(input bce_flags_s f);
        bce_unsigned_above = ~bce_unsigned_at_most(f);
    endfunction

    function automatic logic bce_arith_wrap_clear(input bce_flags_s f);
        bce_arith_wrap_clear = ~bce_arith_wrap_set(f);
    endfunction

    function automatic logic bce_nonnegative_result(input bce_flags_s f);
        bce_nonnegative_result = ~bce_negative_result(f);
    endfunction

    function automatic logic bce_operands_differ(input bce_flags_s f);
        bce_operands_differ = ~bce_operands_match(f);
    endfunction

    function automatic logic bce_unsigned_at_least(input bce_flags_s f);
        bce_unsigned_at_least = ~bce_unsigned_below(f);
    endfunction

    // Each of the 16 selector codes fills its own slot, so no two tests share one
    function automatic bce_vec_t bce_all_tests(input bce_flags_s f);
        bce_vec_t t;
        t = '0;
        t[BCE_NEVER] = bce_never();
        t[BCE_SIGNED_BELOW] = bce_signed_below(f);
        t[BCE_SIGNED_AT_MOST] = bce_signed_at_most(f);
        t[BCE_UNSIGNED_AT_MOST] = bce_unsigned_at_most(f);
        t[BCE_ARITH_WRAP_SET] = bce_arith_wrap_set(f);
        t[BCE_NEGATIVE_RESULT] = bce_negative_result(f);
        t[BCE_OPERANDS_MATCH] = bce_operands_match(f);
        t[BCE_UNSIGNED_BELOW] = bce_unsigned_below(f);

        // Upper half mirrors the lower half
        t[BCE_ALWAYS] = bce_always();
        t[BCE_SIGNED_AT_LEAST] = bce_signed_at_least(f);
        t[BCE_SIGNED_ABOVE] = bce_signed_above(f);
        t[BCE_UNSIGNED_ABOVE] = bce_unsigned_above(f);
        t[BCE_ARITH_WRAP_CLEAR] = bce_arith_wrap_clear(f);
        t[BCE_NONNEGATIVE_RESULT] = bce_nonnegative_result(f);
        t[BCE_OPERANDS_DIFFER] = bce_operands_differ(f);
        t[BCE_UNSIGNED_AT_LEAST] = bce_unsigned_at_least(f);
        bce_all_tests = t;
    endfunction

    // And-or select; one hot bit lets exactly one test through
    function automatic logic bce_pick(input bce_vec_t hot, input bce_vec_t tests);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < BCE_N_TESTS; i++)
        begin
            hit = hit | (hot[i] & tests[i]);
        end
        bce_pick = hit;
    endfunction

    // Flags are only read here, so evaluation cannot disturb them
    always_comb
    begin
        eval_now = '0;
        eval_now.flags = bce_bundle(flag_carry, flag_zero, flag_sign, flag_overflow);
        eval_now.sel = bce_select(opcode);
        eval_now.hot = bce_onehot(eval_now.sel);
        eval_now.tests = bce_all_tests(eval_now.flags);
        eval_now.hit = bce_pick(eval_now.hot, eval_now.tests);
    end

    // No register: the decision follows the inputs in the same cycle
    always_comb
    begin
        branch_condition_field = eval_now.sel;
        take_jump = is_conditional_jump & eval_now.hit;
    end
endmodule
`default_nettype wire
